// [verilog/mb_slave_defines.svh]
// Constants of the serial register protocol slave: codes, offsets, timing.
`ifndef MB_SLAVE_DEFINES_SVH
`define MB_SLAVE_DEFINES_SVH
// ****************************************************************
// Frame check.
// ****************************************************************
`define MB_CRC_INIT       16'hFFFF
`define MB_CRC_POLY       16'hA001
// ****************************************************************
// Frame layout and function codes.
// ****************************************************************
`define MB_FN_READ        8'h03
`define MB_FN_WRITE       8'h06
`define MB_RD_MAX_WORDS   12
`define MB_FRAME_BYTES    8
`define MB_BCAST_ADDR     8'h00
`define MB_STATION_MAX    8'hF7
// ****************************************************************
// Register address map.
// ****************************************************************
`define MB_RUN_CMD_ADDR   16'h1000
`define MB_RUN_CMD_RST    16'h0000
`define MB_RUN_CODE_MAX   16'h0007
`define MB_VOL_BIT        15
`define MB_HIGRP_OFFSET   15'h4200
`define MB_HIGRP_BASE     15'h5200
`define MB_LOGRP_END      15'h1000
// ****************************************************************
// Line timing: clock, baud, bits per character, gaps in half chars.
// ****************************************************************
`define MB_CLK_HZ         20000000
`define MB_BAUD           9600
`define MB_CHAR_BITS      11
`define MB_GAP_FRAME_X2   7
`define MB_GAP_CHAR_X2    3
`endif

// [verilog/mb_slave_pkg.sv]
// Types shared by the protocol slave and its neighbours.
package mb_slave_pkg;
  // Handler states.
  typedef enum logic [2:0] {
    S_RX    = 3'b000,
    S_CHECK = 3'b001,
    S_HDR   = 3'b010,
    S_ACC   = 3'b011,
    S_DATA  = 3'b100,
    S_CRC   = 3'b101
  } state_e;
  // One access to the parameter store.
  typedef struct packed {
    logic        wr;
    logic        vol;
    logic [14:0] addr;
    logic [15:0] wdata;
  } par_req_s;
  // Result of decoding a protocol address.
  typedef struct packed {
    logic        ok;
    logic        run;
    logic        vol;
    logic [14:0] addr;
  } addr_map_s;
endpackage : mb_slave_pkg

// [verilog/mb_tx_fifo.sv]
// Byte FIFO between the reply builder and the line transmitter.
module mb_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             i_core_clk,
  input  wire logic             i_srst,
  // Filling side.
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Draining side.
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("mb_tx_fifo needs a power of two depth of at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             load;
  // Output stage is a register, so the drain side sees flop outputs.
  assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign push       = i_in_valid && o_in_ready;
  assign load       = (cnt_reg != '0) && (!o_out_valid || i_out_ready);
  // Storage writes.
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end
  // Pointers and fill count.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end
  // Output register stage.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else if (load) begin
      o_out_valid <= 1'b1;
      o_out_data  <= mem_reg[rd_ptr_reg];
    end else if (i_out_ready) begin
      o_out_valid <= 1'b0;
    end
  end
endmodule : mb_tx_fifo

// [verilog/mb_rtu_slave.sv]
// Slave command handler for read-block and write-word register frames.
//
// Contract
// - Read asks at most twelve words, all returned.
// - Read reply: address, function, byte count, words.
// - Write one word; reply echoes request fields.
// - Two-byte check ends frame; mismatch is error.
// - Check starts all ones; data bits only.
// - Xor byte, eight shifts, polynomial on carry.
// - Address is group high, index low.
// - Direct group byte 0..15, index any.
// - Top address bit selects volatile alias.
// - Groups above fifteen carry fixed offset.
// - Run word takes forward, reverse, jog codes.
// - Silence delimits frames; 1.5-char gap drops partial frame.
// - Stations 1..247; broadcast writes acted, unanswered.
`include "mb_slave_defines.svh"
module mb_rtu_slave #(
  parameter int CHAR_CYCLES =
    (`MB_CLK_HZ * `MB_CHAR_BITS + `MB_BAUD - 1) / `MB_BAUD,
  parameter int FIFO_DEPTH  = 8
) (
  // Clock and reset.
  input  wire logic                   i_core_clk,
  input  wire logic                   i_srst,
  // Configuration.
  input  wire logic [7:0]             i_station_addr,
  // Received bytes from the line receiver.
  input  wire logic                   i_rx_valid,
  input  wire logic [7:0]             i_rx_data,
  // Reply bytes to the line transmitter.
  output logic                        o_tx_valid,
  output logic [7:0]                  o_tx_data,
  input  wire logic                   i_tx_ready,
  // Parameter store access.
  output logic                        o_par_req,
  output mb_slave_pkg::par_req_s      o_par,
  input  wire logic                   i_par_ack,
  input  wire logic [15:0]            i_par_rdata,
  // Run command word and status.
  output logic [15:0]                 o_run_cmd,
  output logic                        o_crc_err,
  output logic                        o_busy
);
  localparam int T15 = (CHAR_CYCLES * `MB_GAP_CHAR_X2 + 1) / 2;
  localparam int T35 = (CHAR_CYCLES * `MB_GAP_FRAME_X2 + 1) / 2;
  localparam int GW  = $clog2(T35 + 1);
  localparam logic [GW-1:0] T15_C = GW'(T15);
  localparam logic [GW-1:0] T35_C = GW'(T35);
  generate
    if (CHAR_CYCLES < 2) begin : g_chk
      $error("mb_rtu_slave needs at least two cycles per character");
    end
  endgenerate

  // ****************************************************************
  // Frame check arithmetic.
  // ****************************************************************
  // Byte-wise check, shared by receive and transmit.
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  function automatic mb_slave_pkg::addr_map_s map_addr(
      input logic [15:0] a);
    mb_slave_pkg::addr_map_s m;
    m.vol  = a[`MB_VOL_BIT];
    m.run  = (a == `MB_RUN_CMD_ADDR);
    m.addr = a[14:0];
    m.ok   = m.run || (a[14:0] < `MB_LOGRP_END);
    if (!m.run && a[14:0] >= `MB_HIGRP_BASE) begin
      m.addr = a[14:0] - `MB_HIGRP_OFFSET;
      m.ok   = 1'b1;
    end
    return m;
  endfunction : map_addr

  // ****************************************************************
  // Receive side.
  // ****************************************************************
  mb_slave_pkg::state_e state_reg;
  logic [7:0]  rx_buf_reg [0:`MB_FRAME_BYTES-1];
  logic [3:0]  rx_cnt_reg;
  logic        rx_ovf_reg;
  logic [15:0] rx_crc_reg;
  logic [GW-1:0] gap_reg;
  logic        rx_take;
  logic        gap_drop;
  logic        frame_end;
  logic        frame_full;

  assign rx_take   = (state_reg == mb_slave_pkg::S_RX) && i_rx_valid;
  assign gap_drop  = (gap_reg == T15_C) && (rx_cnt_reg != 4'd0) &&
                     (rx_cnt_reg < 4'(`MB_FRAME_BYTES));
  assign frame_end = (gap_reg == T35_C) && (rx_cnt_reg != 4'd0);
  assign frame_full = (state_reg == mb_slave_pkg::S_RX) && frame_end &&
                      (rx_cnt_reg == 4'(`MB_FRAME_BYTES)) && !rx_ovf_reg;

  // Silence counter since the last received byte.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || rx_take) begin
      gap_reg <= '0;
    end else if (gap_reg != T35_C) begin
      gap_reg <= gap_reg + GW'(1);
    end
  end

  // Collect bytes and run the check over all of them.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || state_reg != mb_slave_pkg::S_RX || gap_drop ||
        frame_end) begin
      rx_cnt_reg <= 4'd0;
      rx_ovf_reg <= 1'b0;
      // A complete frame keeps its remainder for the one check cycle.
      rx_crc_reg <= (!i_srst && frame_full) ? rx_crc_reg : `MB_CRC_INIT;
    end else if (rx_take) begin
      rx_crc_reg <= crc_byte(rx_crc_reg, i_rx_data);
      if (rx_cnt_reg < 4'(`MB_FRAME_BYTES)) begin
        rx_buf_reg[rx_cnt_reg[2:0]] <= i_rx_data;
        rx_cnt_reg <= rx_cnt_reg + 4'd1;
      end else begin
        rx_ovf_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Request decode.
  // ****************************************************************
  logic [15:0] req_addr;
  logic [15:0] req_val;
  logic        is_read;
  logic        is_write;
  logic        addr_hit;
  logic        is_bcast;
  logic        frame_ok;
  mb_slave_pkg::addr_map_s req_map;
  assign req_addr = {rx_buf_reg[2], rx_buf_reg[3]};
  assign req_val  = {rx_buf_reg[4], rx_buf_reg[5]};
  assign is_read  = (rx_buf_reg[1] == `MB_FN_READ);
  assign is_write = (rx_buf_reg[1] == `MB_FN_WRITE);
  assign is_bcast = (rx_buf_reg[0] == `MB_BCAST_ADDR);
  // Only a legal station number matches its own frames.
  assign addr_hit = is_bcast || ((rx_buf_reg[0] == i_station_addr) &&
                    (i_station_addr <= `MB_STATION_MAX));
  // Whole frame check must leave a zero remainder.
  assign req_map  = map_addr(req_addr);
  assign frame_ok = (rx_crc_reg == 16'h0000) && addr_hit &&
                    req_map.ok && (is_write ||
                    (is_read && req_val != 16'h0000 &&
                     req_val <= 16'(`MB_RD_MAX_WORDS)));

  // ****************************************************************
  // Reply sequencing.
  // ****************************************************************
  logic [2:0]  idx_reg;
  logic [3:0]  words_reg;
  logic [15:0] cur_reg;
  logic [15:0] word_reg;
  logic [15:0] tx_crc_reg;
  logic        bcast_reg;
  logic [15:0] run_reg;
  logic        push_valid;
  logic        push_ready;
  logic        push;
  logic [7:0]  push_byte;
  mb_slave_pkg::addr_map_s cur_map;
  assign cur_map = map_addr(cur_reg);

  // Byte presented to the reply FIFO in each state.
  always_comb begin
    push_valid = !bcast_reg;
    push_byte  = 8'h00;
    unique case (state_reg)
      mb_slave_pkg::S_HDR: begin
        push_byte = (is_read && idx_reg == 3'd2) ?
                    {3'b000, words_reg, 1'b0} : rx_buf_reg[idx_reg];
      end
      mb_slave_pkg::S_DATA: begin
        push_byte = (idx_reg == 3'd0) ? word_reg[15:8] : word_reg[7:0];
      end
      mb_slave_pkg::S_CRC: begin
        push_byte = (idx_reg == 3'd0) ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
      end
      default: begin
        push_valid = 1'b0;
      end
    endcase
  end
  assign push = push_valid && push_ready;

  // Main sequencer; one store access per word except the run word, one byte per accepted push.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_reg <= mb_slave_pkg::S_RX;
      idx_reg   <= 3'd0;
      words_reg <= 4'd0;
      cur_reg   <= 16'h0000;
      word_reg  <= 16'h0000;
      bcast_reg <= 1'b0;
      o_par_req <= 1'b0;
      o_par     <= '0;
    end else begin
      unique case (state_reg)
        mb_slave_pkg::S_RX: begin
          // Only a full-length frame after the long silence counts.
          if (frame_full) begin
            state_reg <= mb_slave_pkg::S_CHECK;
          end
        end
        mb_slave_pkg::S_CHECK: begin
          idx_reg   <= 3'd0;
          cur_reg   <= req_addr;
          words_reg <= is_read ? req_val[3:0] : 4'd1;
          bcast_reg <= is_bcast;
          // Discard, or act; broadcast reads do nothing.
          if (!frame_ok || (is_bcast && is_read)) begin
            state_reg <= mb_slave_pkg::S_RX;
          end else begin
            state_reg <= is_read ? mb_slave_pkg::S_HDR :
                                   mb_slave_pkg::S_ACC;
          end
        end
        mb_slave_pkg::S_HDR: begin
          if (push) begin
            idx_reg <= idx_reg + 3'd1;
            if (idx_reg == (is_read ? 3'd2 : 3'd5)) begin
              idx_reg   <= 3'd0;
              state_reg <= is_read ? mb_slave_pkg::S_ACC :
                                     mb_slave_pkg::S_CRC;
            end
          end
        end
        mb_slave_pkg::S_ACC: begin
          if (cur_map.run || (o_par_req && i_par_ack)) begin
            o_par_req <= 1'b0;
            word_reg  <= cur_map.run ? run_reg : i_par_rdata;
            // Writes echo next, broadcasts stay silent.
            if (is_write) begin
              state_reg <= bcast_reg ? mb_slave_pkg::S_RX :
                                       mb_slave_pkg::S_HDR;
            end else begin
              state_reg <= mb_slave_pkg::S_DATA;
            end
          end else if (!o_par_req) begin
            // Volatile alias passes through to the store.
            o_par_req   <= 1'b1;
            o_par.wr    <= is_write;
            o_par.vol   <= cur_map.vol;
            o_par.addr  <= cur_map.addr;
            o_par.wdata <= req_val;
          end
        end
        mb_slave_pkg::S_DATA: begin
          if (push) begin
            idx_reg <= idx_reg + 3'd1;
            // Every requested word goes out, then the check.
            if (idx_reg == 3'd1) begin
              idx_reg   <= 3'd0;
              words_reg <= words_reg - 4'd1;
              cur_reg   <= cur_reg + 16'h0001;
              state_reg <= (words_reg == 4'd1) ? mb_slave_pkg::S_CRC :
                                                 mb_slave_pkg::S_ACC;
            end
          end
        end
        mb_slave_pkg::S_CRC: begin
          if (push) begin
            idx_reg <= idx_reg + 3'd1;
            if (idx_reg == 3'd1) begin
              idx_reg   <= 3'd0;
              state_reg <= mb_slave_pkg::S_RX;
            end
          end
        end
        default: begin
          state_reg <= mb_slave_pkg::S_RX;
        end
      endcase
    end
  end

  // Reply check follows each byte as it enters the FIFO.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || state_reg == mb_slave_pkg::S_CHECK) begin
      tx_crc_reg <= `MB_CRC_INIT;
    end else if (push && state_reg != mb_slave_pkg::S_CRC) begin
      tx_crc_reg <= crc_byte(tx_crc_reg, push_byte);
    end
  end

  // Run command word; codes outside the known set are ignored.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      run_reg <= `MB_RUN_CMD_RST;
    end else if (state_reg == mb_slave_pkg::S_ACC && is_write &&
                 cur_map.run && req_val != 16'h0000 &&
                 req_val <= `MB_RUN_CODE_MAX) begin
      run_reg <= req_val;
    end
  end

  // Status flops; a dropped frame flags only a check mismatch.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_run_cmd <= `MB_RUN_CMD_RST;
      o_crc_err <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      o_run_cmd <= run_reg;
      o_crc_err <= (state_reg == mb_slave_pkg::S_CHECK) &&
                   (rx_crc_reg != 16'h0000);
      o_busy    <= (state_reg != mb_slave_pkg::S_RX);
    end
  end

  // Reply FIFO; a stalled transmitter holds the sequencer back.
  mb_tx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_core_clk  (i_core_clk),
    .i_srst      (i_srst),
    .i_in_valid  (push_valid),
    .i_in_data   (push_byte),
    .o_in_ready  (push_ready),
    .o_out_valid (o_tx_valid),
    .o_out_data  (o_tx_data),
    .i_out_ready (i_tx_ready)
  );

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  chk_read_limit: assert property (
    state_reg == mb_slave_pkg::S_ACC |-> words_reg <= 4'd12)
    else $error("read word count above twelve");
  chk_crc_seed: assert property (
    state_reg == mb_slave_pkg::S_HDR && idx_reg == 3'd0 && !$past(push)
    |-> tx_crc_reg == 16'hFFFF)
    else $error("reply check not seeded with all ones");
  chk_crc_low_first: assert property (
    push && state_reg == mb_slave_pkg::S_CRC && idx_reg == 3'd0
    |-> push_byte == tx_crc_reg[7:0] ##1 push_valid [*1])
    else $error("check low byte not sent first");
  chk_bcast_silent: assert property (
    bcast_reg && state_reg != mb_slave_pkg::S_CHECK |-> !push_valid)
    else $error("broadcast frame produced a reply");
  chk_bad_drop: assert property (
    state_reg == mb_slave_pkg::S_CHECK && rx_crc_reg != 16'h0000
    |=> state_reg == mb_slave_pkg::S_RX && o_crc_err)
    else $error("bad check frame not discarded");
  chk_gap_drop: assert property (
    state_reg == mb_slave_pkg::S_RX && gap_drop && !i_rx_valid
    |=> rx_cnt_reg == 4'd0)
    else $error("partial frame kept after gap");
  chk_run_codes: assert property (
    $changed(run_reg) |-> run_reg >= 16'h0001 && run_reg <= 16'h0007)
    else $error("illegal run code stored");
  chk_byte_count: assert property (
    push && state_reg == mb_slave_pkg::S_HDR && is_read && idx_reg == 3'd2
    |-> push_byte == {req_val[6:0], 1'b0})
    else $error("byte count not twice word count");
  chk_vol_alias: assert property (
    $rose(o_par_req) |-> o_par.vol == cur_reg[15] &&
    o_par.wr == is_write)
    else $error("volatile alias bit not passed on");
  cov_read_reply: cover property (
    state_reg == mb_slave_pkg::S_CRC && push && idx_reg == 3'd1 && is_read);
  cov_write_echo: cover property (
    state_reg == mb_slave_pkg::S_CRC && push && idx_reg == 3'd1 && is_write);
  cov_bcast_write: cover property (
    bcast_reg && state_reg == mb_slave_pkg::S_ACC && is_write);
  cov_crc_error: cover property (o_crc_err);
endmodule : mb_rtu_slave

// [sim/mb_master_model.sv]
// Bus master model: sends request frames and collects reply bytes.
module mb_master_model (
  // Clock and pacing mode.
  input  wire logic       i_core_clk,
  input  wire logic       i_slow,
  // Request bytes towards the slave.
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  // Reply bytes from the slave.
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [1:0] pace;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b0;
    pace       = 2'h0;
  end

  // A slow master takes one byte in four cycles, so the FIFO backs up.
  always @(posedge i_core_clk) begin
    if (o_tx_ready && i_tx_valid === 1'b1) begin
      got.push_back(i_tx_data);
    end
    pace <= pace + 2'h1;
    o_tx_ready <= !i_slow || pace == 2'h3;
  end

  function automatic logic [15:0] crc(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
    end
    return c;
  endfunction : crc

  // check appended low byte first, tight pacing
  task automatic send(input logic [7:0] f[$], input bit add, input bit bad);
    logic [15:0] c;
    c = crc(f) ^ {15'h0000, bad};
    if (add) begin
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
    end
    foreach (f[i]) begin
      @(posedge i_core_clk);
      o_rx_valid <= 1'b1;
      o_rx_data  <= f[i];
      @(posedge i_core_clk);
      o_rx_valid <= 1'b0;
      o_rx_data  <= ~f[i]; // Idle line shows no stale byte.
      repeat (8) @(posedge i_core_clk);
    end
  endtask : send
endmodule : mb_master_model

// [sim/modbus_rtu_slave_command_handler_tb.sv]
// Self-checking bench of the slave command handler.
module modbus_rtu_slave_command_handler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        i_srst;
  logic [7:0]  station;
  logic        slow;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic        o_par_req;
  logic        par_ack;
  logic [15:0] par_rdata;
  logic [15:0] o_run_cmd;
  logic        o_crc_err;
  logic        o_busy;
  logic [1:0]  dly;
  int          errors;
  int          samples_checked;
  int          crc_errs;
  logic [7:0]  e[$];
  mb_slave_pkg::par_req_s o_par;
  mb_slave_pkg::par_req_s last_par;

  // Short characters keep the silence counts small: T35 70, T15 30.
  mb_rtu_slave #(.CHAR_CYCLES(20), .FIFO_DEPTH(8)) i_dut (
    .i_core_clk(clk), .i_srst(i_srst), .i_station_addr(station),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .o_par_req(o_par_req), .o_par(o_par), .i_par_ack(par_ack),
    .i_par_rdata(par_rdata), .o_run_cmd(o_run_cmd),
    .o_crc_err(o_crc_err), .o_busy(o_busy));

  mb_master_model i_master (
    .i_core_clk(clk), .i_slow(slow), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready));

  always #25 clk = ~clk;

  // Store answers late; read data elsewhere toggles to expose stale use.
  always @(posedge clk) begin
    par_ack <= 1'b0;
    par_rdata <= ~par_rdata;
    if (o_crc_err === 1'b1) begin
      crc_errs <= crc_errs + 1;
    end
    if (o_par_req === 1'b1 && !par_ack) begin
      dly <= dly + 2'h1;
      if (dly == 2'h2) begin
        par_ack <= 1'b1;
        par_rdata <= {1'b0, o_par.addr} ^ 16'h5A00;
        last_par <= o_par;
        dly <= 2'h0;
      end
    end
  end

  task automatic check(input string name, input logic [32:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("mismatches %0d, comparisons %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Sends a frame, then compares the whole reply; empty means silence.
  task automatic xfer(input logic [7:0] f[$], input logic [7:0] x[$],
                      input bit bad = 1'b0);
    logic [15:0] c;
    int n;
    c = i_master.crc(x);
    if (x.size() > 0) begin
      x.push_back(c[7:0]);
      x.push_back(c[15:8]);
    end
    i_master.got.delete();
    i_master.send(f, 1'b1, bad);
    n = 0;
    while (i_master.got.size() < x.size() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (150) @(posedge clk);
    check("reply length", i_master.got.size(), x.size());
    check("busy after frame", o_busy, 1'b0);
    foreach (x[i]) begin
      if (i < i_master.got.size()) begin
        check("reply byte", i_master.got[i], x[i]);
      end
    end
  endtask : xfer

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    results();
  end

  initial begin
    clk = 1'b0;
    i_srst = 1'b1;
    station = 8'h01;
    slow = 1'b0;
    par_ack = 1'b0;
    par_rdata = 16'h0000;
    dly = 2'h0;
    crc_errs = 0;
    repeat (12) @(posedge clk);
    i_srst <= 1'b0;
    @(posedge clk);
    check("run word reset", o_run_cmd, 16'h0000);
    check("busy reset", {o_busy, tx_valid, o_par_req}, 3'h0);
    xfer('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h02},
         '{8'h01, 8'h03, 8'h04, 8'h5A, 8'h02, 8'h5A, 8'h03});
    xfer('{8'h01, 8'h03, 8'h0F, 8'hFF, 8'h00, 8'h01},
         '{8'h01, 8'h03, 8'h02, 8'h55, 8'hFF});
    check("direct addr", last_par.addr, 15'h0FFF);
    xfer('{8'h01, 8'h03, 8'h58, 8'h06, 8'h00, 8'h01},
         '{8'h01, 8'h03, 8'h02, 8'h4C, 8'h06});
    check("offset addr", {last_par.wr, last_par.addr}, 16'h1606);
    // partial frame dropped after 1.5-char gap
    i_master.send('{8'h01, 8'h03, 8'h00}, 1'b0, 1'b0);
    repeat (40) @(posedge clk);
    xfer('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01},
         '{8'h01, 8'h03, 8'h02, 8'h5A, 8'h02});
    station <= 8'h02;
    // write echo, stored and volatile alias
    for (int v = 0; v < 2; v++) begin
      e = '{8'h02, 8'h06, {v[0], 7'h00}, 8'h03, 8'h13, 8'h88};
      xfer(e, e);
      check("param write", last_par,
            {2'b10 | v[1:0], 15'h0003, 16'h1388});
    end
    xfer('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, '{});
    xfer('{8'h02, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, '{}, 1'b1);
    check("check errors", crc_errs, 1);
    // run codes 1 to 4, echoed and applied
    for (int k = 1; k < 5; k++) begin
      e = '{8'h02, 8'h06, 8'h10, 8'h00, 8'h00, k[7:0]};
      xfer(e, e);
      check("run word", o_run_cmd, k);
    end
    // unknown run code echoed but not applied
    e = '{8'h02, 8'h06, 8'h10, 8'h00, 8'h00, 8'h08};
    xfer(e, e);
    check("run word kept", o_run_cmd, 16'h0004);
    xfer('{8'h02, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01},
         '{8'h02, 8'h03, 8'h02, 8'h00, 8'h04});
    // broadcast write acted unanswered, broadcast read ignored
    xfer('{8'h00, 8'h06, 8'h10, 8'h00, 8'h00, 8'h02}, '{});
    check("broadcast run", o_run_cmd, 16'h0002);
    xfer('{8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, '{});
    // group seventeen without its offset refused
    xfer('{8'h02, 8'h03, 8'h11, 8'h00, 8'h00, 8'h01}, '{});
    xfer('{8'h02, 8'h03, 8'h01, 8'h00, 8'h00, 8'h0D}, '{});
    // twelve words through a stalled FIFO
    slow <= 1'b1;
    e = '{8'h02, 8'h03, 8'h18};
    for (int w = 0; w < 12; w++) begin
      e.push_back(8'h5B);
      e.push_back(w[7:0]);
    end
    xfer('{8'h02, 8'h03, 8'h01, 8'h00, 8'h00, 8'h0C}, e);
    results();
  end
endmodule : modbus_rtu_slave_command_handler_tb
